// ### hdl/fws_serial_port.sv
// Four-wire serial register port with daily alarm registers
`default_nettype none

module fws_serial_port (
  input wire logic ref_clk, // System clock, 50 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic ce, // Chip enable pin, session while high
  input wire logic sclk, // Serial clock pin
  input wire logic si, // Serial data in pin
  input wire logic hour_mode_12, // Twelve-hour mode from control logic
  input wire logic sec_tick, // Seconds carry pulse from prescaler
  output logic so, // Serial data out pin
  output logic so_oe, // Output enable of serial data out
  output logic carry_hold, // High while seconds carry is held
  output logic sec_carry, // Seconds carry pulse to counters
  output logic [7:0] alarm_minute, // Alarm minute register
  output logic [7:0] alarm_hour, // Alarm hour register
  output logic [7:0] alarm_hour24 // Alarm hour decoded to 24-hour BCD
);

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  fws_pkg::fws_pins_type pins_s;
  fws_pkg::fws_pins_type pins_d_ff;
  fws_pkg::fws_pins_type pins_raw;

  assign pins_raw = '{ce: ce, sclk: sclk, si: si};

  fws_sync #(
    .W(3)
  ) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pins_d_ff <= '0;
    end else begin
      pins_d_ff <= pins_s;
    end
  end

  logic ce_rise;
  logic ce_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic samp_edge;
  logic shift_edge;
  logic clk_high_ff;

  assign ce_rise = pins_s.ce && !pins_d_ff.ce;
  assign ce_fall = !pins_s.ce && pins_d_ff.ce;
  assign sclk_rise = pins_s.sclk && !pins_d_ff.sclk;
  assign sclk_fall = !pins_s.sclk && pins_d_ff.sclk;

  // Edge polarity caught from the clock level when enable rises
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clk_high_ff <= 1'b0;
    end else if (ce_rise) begin
      clk_high_ff <= pins_s.sclk;
    end
  end

  // Edges only count inside a session
  assign samp_edge = pins_s.ce && !ce_rise && (clk_high_ff ? sclk_rise : sclk_fall);
  assign shift_edge = pins_s.ce && !ce_rise && (clk_high_ff ? sclk_fall : sclk_rise);

  // ----------------------------------------------------------------
  // Byte assembly
  // ----------------------------------------------------------------
  logic [6:0] rx_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] rx_byte;
  logic byte_done;

  assign rx_byte = {rx_ff, pins_s.si};
  assign byte_done = samp_edge && (bit_cnt_ff == fws_pkg::LAST_BIT);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_ff <= 7'h00;
      bit_cnt_ff <= 3'h0;
    end else if (!pins_s.ce) begin
      rx_ff <= 7'h00;
      bit_cnt_ff <= 3'h0;
    end else if (samp_edge) begin
      rx_ff <= rx_byte[6:0];
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Session control
  // ----------------------------------------------------------------
  fws_pkg::fws_state_type state_ff;
  fws_pkg::fws_state_type nxt_state;
  logic burst_ff;
  logic [3:0] addr_ff;
  logic [3:0] fmt_ff;

  // Unknown format codes fall back to waiting for a new command
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      fws_pkg::ST_IDLE: begin
        if (ce_rise) begin
          nxt_state = fws_pkg::ST_COMMAND;
        end
      end
      fws_pkg::ST_COMMAND: begin
        if (byte_done) begin
          if (rx_byte[3:0] == fws_pkg::FMT_WRITE_SINGLE || rx_byte[3:0] == fws_pkg::FMT_WRITE_BURST) begin
            nxt_state = fws_pkg::ST_WRITE;
          end else if (rx_byte[3:0] == fws_pkg::FMT_READ_SINGLE || rx_byte[3:0] == fws_pkg::FMT_READ_BURST) begin
            nxt_state = fws_pkg::ST_READ;
          end
        end
      end
      fws_pkg::ST_WRITE, fws_pkg::ST_READ: begin
        if (byte_done && !burst_ff) begin
          nxt_state = fws_pkg::ST_COMMAND;
        end
      end
    endcase
    if (!pins_s.ce) begin
      nxt_state = fws_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= fws_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Pointer and format
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      addr_ff <= 4'h0;
      fmt_ff <= 4'h0;
      burst_ff <= 1'b0;
    end else if (byte_done && state_ff == fws_pkg::ST_COMMAND) begin
      addr_ff <= rx_byte[7:4];
      fmt_ff <= rx_byte[3:0];
      burst_ff <= (rx_byte[3:0] == fws_pkg::FMT_WRITE_BURST) || (rx_byte[3:0] == fws_pkg::FMT_READ_BURST);
    end else if (byte_done && burst_ff && (state_ff == fws_pkg::ST_WRITE || state_ff == fws_pkg::ST_READ)) begin
      addr_ff <= addr_ff + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Register bank access
  // ----------------------------------------------------------------
  fws_pkg::fws_write_type wr_ff;
  logic [7:0] rd_data;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ff <= '0;
    end else begin
      wr_ff.en <= byte_done && state_ff == fws_pkg::ST_WRITE;
      wr_ff.addr <= addr_ff;
      wr_ff.data <= rx_byte;
    end
  end

  fws_alarm_regs u_regs (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .rd_addr(addr_ff),
    .wr(wr_ff),
    .rd_data_ff(rd_data),
    .minute_ff(alarm_minute),
    .hour_ff(alarm_hour)
  );

  // ----------------------------------------------------------------
  // Read shifter
  // ----------------------------------------------------------------
  // Read data trails the pointer by a cycle, so the load waits two;
  // half a link clock period leaves ample margin before the first shift.
  logic [1:0] load_cnt_ff;
  logic [7:0] tx_ff;
  logic so_ff;
  logic so_oe_ff;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      load_cnt_ff <= 2'h0;
    end else if (byte_done && nxt_state == fws_pkg::ST_READ) begin
      load_cnt_ff <= fws_pkg::LOAD_DELAY;
    end else if (load_cnt_ff != 2'h0) begin
      load_cnt_ff <= load_cnt_ff - 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_ff <= 8'h00;
      so_ff <= 1'b0;
    end else if (load_cnt_ff == 2'h1) begin
      tx_ff <= rd_data;
    end else if (shift_edge && state_ff == fws_pkg::ST_READ) begin
      so_ff <= tx_ff[7];
      tx_ff <= {tx_ff[6:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      so_oe_ff <= 1'b0;
    end else begin
      so_oe_ff <= (nxt_state == fws_pkg::ST_READ);
    end
  end

  assign so = so_ff;
  assign so_oe = so_oe_ff;

  // ----------------------------------------------------------------
  // Seconds carry hold
  // ----------------------------------------------------------------
  // A second tick while one is pending means a full second has passed
  logic pend_ff;
  logic carry_ff;
  logic hold_ff;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pend_ff <= 1'b0;
      carry_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      hold_ff <= pins_s.ce;
      if (!pins_s.ce) begin
        carry_ff <= sec_tick || pend_ff;
        pend_ff <= 1'b0;
      end else if (sec_tick && pend_ff) begin
        carry_ff <= 1'b1;
        pend_ff <= 1'b1;
      end else begin
        carry_ff <= 1'b0;
        pend_ff <= pend_ff || sec_tick;
      end
    end
  end

  assign sec_carry = carry_ff;
  assign carry_hold = hold_ff;

  // ----------------------------------------------------------------
  // Alarm hour decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] hour_to_24(input logic [7:0] code, input logic mode12);
    logic [4:0] bin;
    logic [4:0] tens;
    if (!mode12) begin
      hour_to_24 = code & fws_pkg::MASK_ALARM_HOUR;
    end else begin
      bin = (code[4] ? 5'h0A : 5'h00) + {1'b0, code[3:0]};
      if (bin == {1'b0, fws_pkg::HOUR_TWELVE}) begin
        bin = 5'h00;
      end
      if (code[fws_pkg::AFTERNOON_BIT]) begin
        bin = bin + {1'b0, fws_pkg::HOUR_TWELVE};
      end
      tens = (bin >= 5'h14) ? 5'h02 : (bin >= 5'h0A) ? 5'h01 : 5'h00;
      hour_to_24 = {2'h0, tens[1:0], 4'(bin - tens * 5'h0A)};
    end
  endfunction

  logic [7:0] hour24_ff;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hour24_ff <= 8'h00;
    end else begin
      hour24_ff <= hour_to_24(alarm_hour, hour_mode_12);
    end
  end

  assign alarm_hour24 = hour24_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sequence cmd_byte_s;
    byte_done && state_ff == fws_pkg::ST_COMMAND;
  endsequence

  sequence data_byte_s;
    byte_done && (state_ff == fws_pkg::ST_WRITE || state_ff == fws_pkg::ST_READ);
  endsequence

  a_session_end_idle: assert property (ce_fall |=> state_ff == fws_pkg::ST_IDLE)
    else $error("session not discarded at enable fall");

  a_polarity_latch: assert property (ce_rise |=> clk_high_ff == $past(pins_s.sclk))
    else $error("edge polarity not caught at enable rise");

  a_cmd_fields: assert property (cmd_byte_s |=> addr_ff == $past(rx_byte[7:4]) && fmt_ff == $past(rx_byte[3:0]))
    else $error("command byte not loaded into pointer and format");

  a_msb_first: assert property (samp_edge && bit_cnt_ff != fws_pkg::LAST_BIT |=> rx_ff[0] == $past(pins_s.si))
    else $error("serial input not shifted in at the low end");

  a_burst_advance: assert property (data_byte_s ##0 burst_ff |=> addr_ff == $past(addr_ff) + 4'h1)
    else $error("burst pointer did not advance by one");

  a_single_back_cmd: assert property (data_byte_s ##0 !burst_ff ##0 pins_s.ce |=> state_ff == fws_pkg::ST_COMMAND)
    else $error("single transfer did not return to command");

  a_write_strobe: assert property (byte_done && state_ff == fws_pkg::ST_WRITE |=> wr_ff.en ##1 !wr_ff.en)
    else $error("write strobe missing or stretched");

  a_read_load: assert property (cmd_byte_s ##0 rx_byte[3:0] == fws_pkg::FMT_READ_SINGLE |=> ##2 tx_ff == $past(rd_data))
    else $error("read data not loaded for single read");

  a_so_quiet: assert property (!shift_edge |=> $stable(so_ff))
    else $error("serial output changed off its shift edge");

  a_carry_held: assert property (pins_s.ce && sec_tick && !pend_ff |=> !carry_ff)
    else $error("seconds carry passed while enable high");

endmodule

`default_nettype wire

// ### hdl/fws_pkg.sv
// Constants and types shared by the four-wire serial register port
//
// Operation
// - Clock low at enable: output rising, sample falling
// - Clock high at enable: output falling, sample rising
// - Session spans enable high; falling edge discards it
// - Traffic moves in whole eight-bit bytes
// - Command upper nibble loads the address pointer
// - Command lower nibble stores the transfer format
// - Every byte shifts most significant bit first
// - Format 8h writes one byte at pointer
// - After single write, next byte is command
// - Format 0h writes bytes in a burst
// - Burst advances pointer, Fh wraps to 0h
// - Burst write ends only when enable falls
// - Format Ch reads one byte at pointer
// - After single read, next byte is command
// - Format 4h reads registers in a burst
// - Burst read ends only when enable falls
// - Hour bit 5: afternoon flag or tens bit
// - Twelve-hour midnight is 12, noon is 32
// - After oscillation stop, alarm fields are undefined
// - Single transfers chain with any following format
// - Seconds carry held while enable high, one second
`default_nettype none

package fws_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_ALARM_MINUTE = 4'hB;
  localparam logic [3:0] ADDR_ALARM_HOUR = 4'hC;
  localparam logic [7:0] MASK_ALARM_MINUTE = 8'h7F;
  localparam logic [7:0] MASK_ALARM_HOUR = 8'h3F;
  localparam logic [7:0] RESET_ALARM = 8'h00;
  localparam int AFTERNOON_BIT = 5;

  // ----------------------------------------------------------------
  // Transfer format codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FMT_WRITE_SINGLE = 4'h8;
  localparam logic [3:0] FMT_WRITE_BURST = 4'h0;
  localparam logic [3:0] FMT_READ_SINGLE = 4'hC;
  localparam logic [3:0] FMT_READ_BURST = 4'h4;

  // ----------------------------------------------------------------
  // Serial framing and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] LOAD_DELAY = 2'h2;
  localparam logic [3:0] HOUR_TWELVE = 4'hC;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_COMMAND,
    ST_WRITE,
    ST_READ
  } fws_state_type;

  typedef struct packed {
    logic ce;
    logic sclk;
    logic si;
  } fws_pins_type;

  typedef struct packed {
    logic en;
    logic [3:0] addr;
    logic [7:0] data;
  } fws_write_type;

endpackage

`default_nettype wire

// ### hdl/fws_sync.sv
// Two-stage synchroniser for the serial link pins
`default_nettype none

module fws_sync #(
  parameter int W = 3
) (
  input wire logic ref_clk, // System clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [W-1:0] async_in, // Pins from outside the domain
  output logic [W-1:0] sync_out // Synchronised copy
);

  logic [W-1:0] meta_ff;

  initial begin
    if (W < 1) begin
      $error("fws_sync: width must be at least one");
    end
  end

  // First stage feeds only the second
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule

`default_nettype wire

// ### hdl/fws_alarm_regs.sv
// Daily alarm minute and hour register bank with registered read data
`default_nettype none

module fws_alarm_regs (
  input wire logic ref_clk, // System clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [3:0] rd_addr, // Read address
  input wire fws_pkg::fws_write_type wr, // Write request
  output logic [7:0] rd_data_ff, // Read data, one cycle after address
  output logic [7:0] minute_ff, // Alarm minute
  output logic [7:0] hour_ff // Alarm hour
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Contents after oscillation stop are undefined anyway; zero is one legal choice
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      minute_ff <= fws_pkg::RESET_ALARM;
      hour_ff <= fws_pkg::RESET_ALARM;
    end else if (wr.en) begin
      if (wr.addr == fws_pkg::ADDR_ALARM_MINUTE) begin
        minute_ff <= wr.data & fws_pkg::MASK_ALARM_MINUTE;
      end
      if (wr.addr == fws_pkg::ADDR_ALARM_HOUR) begin
        hour_ff <= wr.data & fws_pkg::MASK_ALARM_HOUR;
      end
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_ff <= 8'h00;
    end else if (rd_addr == fws_pkg::ADDR_ALARM_MINUTE) begin
      rd_data_ff <= minute_ff;
    end else if (rd_addr == fws_pkg::ADDR_ALARM_HOUR) begin
      rd_data_ff <= hour_ff;
    end else begin
      rd_data_ff <= 8'h00;
    end
  end

  a_unused_bits_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    (minute_ff[7] == 1'b0) && (hour_ff[7:6] == 2'h0) && (rd_data_ff[7] == 1'b0 || rd_addr != $past(rd_addr)))
    else $error("unimplemented alarm bit is set");

  a_write_lands: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr.en && wr.addr == fws_pkg::ADDR_ALARM_HOUR |=> hour_ff == ($past(wr.data) & fws_pkg::MASK_ALARM_HOUR))
    else $error("hour write did not land");

endmodule

`default_nettype wire

// ### tb/fws_host_model.sv
// Host-side model that drives the four-wire serial link
`default_nettype none

module fws_host_model (
  input wire logic ref_clk, // System clock
  input wire logic so, // Serial data out of the device
  output logic ce, // Chip enable
  output logic sclk, // Serial clock
  output logic si // Serial data in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic pol;

  initial begin
    pol = 1'b0;
    ce = 1'b0;
    sclk = 1'b0;
    si = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // -----------------------------------------------------------------
  // Session framing
  // -----------------------------------------------------------------
  // Idle level of sclk at the ce rise picks the edge pair
  task automatic open(input logic p);
    pol = p;
    sclk <= p;
    wait_clk(4);
    ce <= 1'b1;
    wait_clk(6);
  endtask

  // Only the ce fall ends a burst; si is inverted so its last data bit does not linger
  task automatic close();
    ce <= 1'b0;
    si <= ~si;
    wait_clk(8);
  endtask

  // -----------------------------------------------------------------
  // Bit and byte shifting
  // -----------------------------------------------------------------
  // so is taken a full half period after the sample edge, clear of its update
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sclk <= ~pol;
      si <= tx[i];
      wait_clk(4);
      sclk <= pol;
      wait_clk(4);
      rx[i] = so;
    end
  endtask

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    shift(tx, 8, rx);
  endtask

  task automatic cmd(input logic [3:0] addr, input logic [3:0] fmt);
    logic [7:0] d;
    shift({addr, fmt}, 8, d);
  endtask
endmodule

`default_nettype wire

// ### tb/four_wire_serial_register_port_tb_top.sv
// Self-checking bench for the four-wire serial register port
`default_nettype none

`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module four_wire_serial_register_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk;
  logic resetn;
  logic hour_mode_12;
  logic sec_tick;
  logic ce;
  logic sclk;
  logic si;
  logic so;
  logic so_oe;
  logic carry_hold;
  logic sec_carry;
  logic [7:0] alarm_minute;
  logic [7:0] alarm_hour;
  logic [7:0] alarm_hour24;
  logic [7:0] regs [16];
  logic [7:0] rx;
  logic [7:0] v;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int carries = 0;

  fws_serial_port dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .ce(ce), .sclk(sclk), .si(si),
    .hour_mode_12(hour_mode_12), .sec_tick(sec_tick), .so(so), .so_oe(so_oe),
    .carry_hold(carry_hold), .sec_carry(sec_carry), .alarm_minute(alarm_minute),
    .alarm_hour(alarm_hour), .alarm_hour24(alarm_hour24)
  );

  fws_host_model host_u (.ref_clk(ref_clk), .so(so), .ce(ce), .sclk(sclk), .si(si));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // -----------------------------------------------------------------
  // Reference model
  // -----------------------------------------------------------------
  function automatic logic [7:0] bcd(input int n);
    return 8'((n / 10) * 16 + n % 10);
  endfunction

  // Legal times only, with the unimplemented high bits randomly set
  function automatic logic [7:0] rand_val(input logic [3:0] a);
    if (a == fws_pkg::ADDR_ALARM_MINUTE) return bcd($urandom_range(59)) | 8'($urandom & 1) << 7;
    return bcd($urandom_range(12, 1)) | 8'($urandom & 7) << 5;
  endfunction

  function automatic logic [7:0] to24(input logic [7:0] h, input logic m12);
    int hr;
    if (!m12) return h & 8'h3F;
    hr = h[4] * 10 + h[3:0];
    if (hr == 12) hr = 0;
    if (h[5]) hr = hr + 12;
    return bcd(hr);
  endfunction

  function automatic void ref_write(input logic [3:0] a, input logic [7:0] d);
    if (a == fws_pkg::ADDR_ALARM_MINUTE) regs[a] = d & 8'h7F;
    if (a == fws_pkg::ADDR_ALARM_HOUR) regs[a] = d & 8'h3F;
  endfunction

  // -----------------------------------------------------------------
  // Transfers and checks
  // -----------------------------------------------------------------
  task automatic write1(input logic [3:0] a, input logic [7:0] d);
    host_u.cmd(a, fws_pkg::FMT_WRITE_SINGLE);
    host_u.xfer(d, rx);
    ref_write(a, d);
  endtask

  task automatic read1(input logic [3:0] a);
    host_u.cmd(a, fws_pkg::FMT_READ_SINGLE);
    host_u.xfer(8'h00, rx);
    `CHK(rx, regs[a])
  endtask

  task automatic check_regs();
    `CHK(alarm_minute, regs[11])
    `CHK(alarm_hour, regs[12])
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (sec_carry !== 1'b0) carries++;
  end

  // Whole run needs about 4400 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    resetn = 1'b0;
    hour_mode_12 = 1'b0;
    sec_tick = 1'b0;
    regs = '{default: fws_pkg::RESET_ALARM};
    void'($urandom(32'hBC579E72));
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // Chained single transfers under both edge pairs
    for (int p = 0; p < 2; p++) begin
      host_u.open(p[0]);
      write1(fws_pkg::ADDR_ALARM_MINUTE, rand_val(fws_pkg::ADDR_ALARM_MINUTE));
      read1(fws_pkg::ADDR_ALARM_MINUTE);
      write1(fws_pkg::ADDR_ALARM_HOUR, rand_val(fws_pkg::ADDR_ALARM_HOUR));
      read1(fws_pkg::ADDR_ALARM_HOUR);
      read1(4'h3);
      host_u.close();
      check_regs();
    end
    // Hour decoding, midnight and noon first
    hour_mode_12 <= 1'b1;
    host_u.open(1'($urandom));
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 8'h12 : (k == 1) ? 8'h32 : rand_val(fws_pkg::ADDR_ALARM_HOUR);
      write1(fws_pkg::ADDR_ALARM_HOUR, v);
      // Decoded hour trails the register write by a cycle
      host_u.wait_clk(3);
      `CHK(alarm_hour24, to24(regs[12], 1'b1))
    end
    hour_mode_12 <= 1'b0;
    host_u.wait_clk(3);
    `CHK(alarm_hour24, to24(regs[12], 1'b0))
    host_u.close();
    // Refused format, then a burst write that wraps past Fh
    host_u.open(1'($urandom));
    host_u.cmd(fws_pkg::ADDR_ALARM_HOUR, 4'h1);
    host_u.cmd(4'hD, fws_pkg::FMT_WRITE_BURST);
    host_u.wait_clk(3);
    check_regs();
    for (int i = 0; i < 16; i++) begin
      v = rand_val(4'(13 + i));
      host_u.xfer(v, rx);
      ref_write(4'(13 + i), v);
    end
    host_u.close();
    check_regs();
    // Burst read that wraps and revisits the alarm minute register
    host_u.open(1'($urandom));
    host_u.cmd(4'hA, fws_pkg::FMT_READ_BURST);
    for (int i = 0; i < 18; i++) begin
      host_u.xfer(8'h00, rx);
      `CHK(rx, regs[4'(10 + i)])
    end
    `CHK(so_oe, 1'b1)
    host_u.close();
    `CHK(so_oe, 1'b0)
    // Torn data byte with a seconds carry held across the session
    host_u.open(1'($urandom));
    host_u.cmd(fws_pkg::ADDR_ALARM_MINUTE, fws_pkg::FMT_WRITE_SINGLE);
    sec_tick <= 1'b1;
    @(posedge ref_clk);
    sec_tick <= 1'b0;
    host_u.shift(8'h55, 5, rx);
    `CHK(carries, 0)
    `CHK(carry_hold, 1'b1)
    // A second tick inside one hold means a full second has passed
    sec_tick <= 1'b1;
    @(posedge ref_clk);
    sec_tick <= 1'b0;
    host_u.wait_clk(3);
    `CHK(carries, 1)
    host_u.close();
    `CHK(carries, 2)
    check_regs();
    stop_test();
  end
endmodule

`default_nettype wire
